// file: common/hbtb_defs.svh
`ifndef HBTB_DEFS_SVH
`define HBTB_DEFS_SVH

// Queue and cache sizes
`define HBTB_DRAW_DEPTH 64
`define HBTB_DIRECT_DEPTH 8
`define HBTB_DUMP_DEPTH 4
`define HBTB_CACHE_WORDS 4

// Reserved VGA-space address that invalidates the read cache
`define HBTB_INVALIDATE_OFS 13'h1fff

// Timing, in bus clocks
`define HBTB_INIT_PHASE_MAX 16
`define HBTB_HIT_CYCLES 2

`endif

// file: common/hbtb_pkg.sv
package hbtb_pkg;

  typedef enum logic [1:0] {
    SP_MEM,
    SP_IO,
    SP_CONFIG
  } hbtb_space_t;

  typedef enum logic [3:0] {
    CLS_CONFIG,
    CLS_HOSTREG,
    CLS_VGAREG,
    CLS_DRAWREG,
    CLS_INDIRECT,
    CLS_PSEUDO_DMA_WINDOW,
    CLS_ROM,
    CLS_DAC,
    CLS_EXPANSION,
    CLS_VGAFB,
    CLS_FRAME
  } hbtb_class_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_FETCH,
    ST_GAP
  } hbtb_state_t;

endpackage : hbtb_pkg

// file: rtl/hbtb_target.sv
`include "hbtb_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module hbtb_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] mem_cnt_reg;
  logic [AW:0] mem_cnt_next;
  logic [AW:0] total_next;
  logic out_valid_reg;
  logic out_valid_next;
  logic [WIDTH-1:0] out_data_reg;
  logic in_ready_reg;
  logic push;
  logic load;

  assign push = in_valid & in_ready_reg;
  assign load = (mem_cnt_reg != '0) & (~out_valid_reg | out_ready);
  assign mem_cnt_next = mem_cnt_reg + (AW+1)'(push) - (AW+1)'(load);
  assign out_valid_next = load | (out_valid_reg & ~out_ready);
  assign total_next = mem_cnt_next + (AW+1)'(out_valid_next);
  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign level = mem_cnt_reg + (AW+1)'(out_valid_reg);

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      mem_cnt_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
      in_ready_reg <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (load)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
        out_data_reg <= mem[rd_ptr_reg];
      end
      mem_cnt_reg <= mem_cnt_next;
      out_valid_reg <= out_valid_next;
      // Back-pressure counts the output stage too
      in_ready_reg <= (total_next < (AW+1)'(DEPTH));
    end
  end

endmodule : hbtb_fifo

module hbtb_target #(
  parameter int ADDR_W = 24,
  parameter int DRAW_DEPTH = `HBTB_DRAW_DEPTH,
  parameter int DIRECT_DEPTH = `HBTB_DIRECT_DEPTH,
  parameter int DUMP_DEPTH = `HBTB_DUMP_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire hbtb_pkg::hbtb_space_t req_space,
  input wire hbtb_pkg::hbtb_class_t req_class,
  input wire logic req_write,
  input wire logic req_first,
  input wire logic req_more,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [3:0] byte_enable_pins_n,
  input wire logic [7:0] io_lane_unit,
  input wire logic [31:0] req_wdata,
  input wire logic native_mode,
  input wire logic retry_disable,
  output logic resp_ack,
  output logic resp_stop,
  output logic resp_abort,
  output logic [31:0] resp_rdata,
  output logic abort_flag,
  input wire logic abort_flag_clear,
  output logic draw_valid,
  input wire logic draw_ready,
  output logic [ADDR_W+39:0] draw_data,
  output logic dir_valid,
  input wire logic dir_ready,
  output logic [ADDR_W+39:0] dir_data,
  input wire logic dump_valid,
  output logic dump_ready,
  input wire logic [31:0] dump_data,
  output logic fetch_req,
  output logic [ADDR_W-1:0] fetch_addr,
  output logic fetch_single,
  input wire logic fetch_valid,
  input wire logic fetch_last,
  input wire logic [31:0] fetch_data,
  output logic reg_strobe,
  output logic reg_write,
  output hbtb_pkg::hbtb_class_t reg_class,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [3:0] reg_be_n,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);

  localparam int EW = ADDR_W + 40;
  localparam int TAG_W = ADDR_W - 4;

  // ----------------------------------------------------------------
  // Byte-enable checks
  // ----------------------------------------------------------------
  function automatic logic lane_bad(input logic [1:0] lane, input logic [3:0] ben);
    logic bad;
    bad = 1'b0;
    if (ben != 4'hf)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (i < int'(lane) && !ben[i])
        begin
          bad = 1'b1;
        end
        if (i > int'(lane) && !ben[i] && ben[lane])
        begin
          bad = 1'b1;
        end
      end
    end
    return bad;
  endfunction : lane_bad

  function automatic logic multi_unit(input logic [3:0] ben, input logic [7:0] unit);
    logic multi;
    multi = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      for (int j = 0; j < 4; j++)
      begin
        if (!ben[i] && !ben[j] && unit[2*i +: 2] != unit[2*j +: 2])
        begin
          multi = 1'b1;
        end
      end
    end
    return multi;
  endfunction : multi_unit

  // ----------------------------------------------------------------
  // State and queues
  // ----------------------------------------------------------------
  hbtb_pkg::hbtb_state_t state_reg;
  logic ack_reg, stop_reg, abort_reg, abort_flag_reg;
  logic [31:0] rdata_reg;
  logic lat_src_reg, lat_stop_reg, lat_flush_reg;
  logic [1:0] lat_word_reg;
  logic [TAG_W-1:0] lat_tag_reg;
  logic lat_slow_reg;

  logic cache_valid_reg, cache_busy_reg, cache_stale_reg, cache_slow_reg;
  logic [TAG_W-1:0] cache_tag_reg;
  logic [1:0] fill_idx_reg;
  logic [31:0] cache_data [`HBTB_CACHE_WORDS];
  logic fetch_req_reg, fetch_single_reg;
  logic [ADDR_W-1:0] fetch_addr_reg;

  logic reg_strobe_reg, reg_write_reg;
  hbtb_pkg::hbtb_class_t reg_class_reg;
  logic [ADDR_W-1:0] reg_addr_reg;
  logic [3:0] reg_be_n_reg;
  logic [31:0] reg_wdata_reg;

  logic draw_in_ready, dir_in_ready, dump_out_valid;
  logic [31:0] dump_out_data;
  logic [$clog2(DIRECT_DEPTH):0] dir_level;
  logic [EW-1:0] entry;

  logic take, is_cached, is_slow, hit, burst_ok;
  logic d_abort, d_retry, d_ack, d_hold, d_src_reg, d_fetch_wait, d_stop_data;
  logic d_push_draw, d_push_dir, d_pop_dump, d_reg, d_flush, d_fetch_start, d_lat_flush;
  logic flush_now;
  logic [31:0] d_rdata;

  assign take = (state_reg == hbtb_pkg::ST_IDLE) & req_valid;
  assign entry = {req_class, byte_enable_pins_n, req_addr, req_wdata};

  hbtb_fifo #(.WIDTH(EW), .DEPTH(DRAW_DEPTH)) u_draw_q (
    .clock(clock),
    .rst(rst),
    .in_valid(d_push_draw),
    .in_ready(draw_in_ready),
    .in_data(entry),
    .out_valid(draw_valid),
    .out_ready(draw_ready),
    .out_data(draw_data),
    .level()
  );

  hbtb_fifo #(.WIDTH(EW), .DEPTH(DIRECT_DEPTH)) u_direct_q (
    .clock(clock),
    .rst(rst),
    .in_valid(d_push_dir),
    .in_ready(dir_in_ready),
    .in_data(entry),
    .out_valid(dir_valid),
    .out_ready(dir_ready),
    .out_data(dir_data),
    .level(dir_level)
  );

  hbtb_fifo #(.WIDTH(32), .DEPTH(DUMP_DEPTH)) u_dump_q (
    .clock(clock),
    .rst(rst),
    .in_valid(dump_valid),
    .in_ready(dump_ready),
    .in_data(dump_data),
    .out_valid(dump_out_valid),
    .out_ready(d_pop_dump),
    .out_data(dump_out_data),
    .level()
  );

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  always_comb
  begin
    is_cached = req_class inside {hbtb_pkg::CLS_ROM, hbtb_pkg::CLS_DAC,
      hbtb_pkg::CLS_EXPANSION, hbtb_pkg::CLS_VGAFB, hbtb_pkg::CLS_FRAME};
    is_slow = req_class inside {hbtb_pkg::CLS_ROM, hbtb_pkg::CLS_DAC, hbtb_pkg::CLS_EXPANSION}
      | (req_class == hbtb_pkg::CLS_VGAFB & ~native_mode);
    hit = cache_valid_reg & ~cache_busy_reg & (cache_slow_reg == is_slow)
      & (cache_tag_reg == req_addr[ADDR_W-1:4]);
    burst_ok = 1'b0;
    if (req_class inside {hbtb_pkg::CLS_PSEUDO_DMA_WINDOW})
    begin
      burst_ok = 1'b1;
    end
    else if (req_write)
    begin
      burst_ok = req_class inside {hbtb_pkg::CLS_DRAWREG, hbtb_pkg::CLS_INDIRECT,
        hbtb_pkg::CLS_VGAFB, hbtb_pkg::CLS_FRAME};
    end
    else
    begin
      burst_ok = hit & ~is_slow & (req_class inside {hbtb_pkg::CLS_VGAFB, hbtb_pkg::CLS_FRAME});
    end
  end

  always_comb
  begin
    d_abort = 1'b0;
    d_retry = 1'b0;
    d_ack = 1'b0;
    d_hold = 1'b0;
    d_src_reg = 1'b0;
    d_fetch_wait = 1'b0;
    d_push_draw = 1'b0;
    d_push_dir = 1'b0;
    d_pop_dump = 1'b0;
    d_reg = 1'b0;
    d_flush = 1'b0;
    d_fetch_start = 1'b0;
    d_lat_flush = 1'b0;
    d_rdata = reg_rdata;
    if (take)
    begin
      if (req_space == hbtb_pkg::SP_IO && (lane_bad(req_addr[1:0], byte_enable_pins_n)
          || multi_unit(byte_enable_pins_n, io_lane_unit)))
      begin
        d_abort = 1'b1;
      end
      else if (req_write)
      begin
        unique case (req_class)
          hbtb_pkg::CLS_DRAWREG, hbtb_pkg::CLS_INDIRECT, hbtb_pkg::CLS_PSEUDO_DMA_WINDOW:
          begin
            d_retry = ~draw_in_ready;
            d_push_draw = draw_in_ready;
            d_ack = draw_in_ready;
          end
          hbtb_pkg::CLS_ROM, hbtb_pkg::CLS_DAC, hbtb_pkg::CLS_EXPANSION,
          hbtb_pkg::CLS_VGAFB, hbtb_pkg::CLS_FRAME:
          begin
            // A pending slow delayed read of any slow class must finish before a DAC write
            d_retry = ~dir_in_ready | (cache_busy_reg & cache_slow_reg
              & req_class == hbtb_pkg::CLS_DAC);
            d_push_dir = ~d_retry;
            d_ack = ~d_retry;
            d_flush = ~d_retry & (req_class inside {hbtb_pkg::CLS_VGAFB,
              hbtb_pkg::CLS_FRAME});
          end
          hbtb_pkg::CLS_VGAREG:
          begin
            d_retry = (dir_level != '0) | (cache_busy_reg & cache_slow_reg);
            d_reg = ~d_retry;
            d_ack = ~d_retry;
            // Any VGA-space write that is not retried, the invalidate address among them, flushes
            d_flush = ~d_retry;
          end
          default:
          begin
            d_reg = 1'b1;
            d_ack = 1'b1;
          end
        endcase
      end
      else if (req_class == hbtb_pkg::CLS_PSEUDO_DMA_WINDOW)
      begin
        d_retry = ~dump_out_valid;
        d_pop_dump = dump_out_valid;
        d_ack = dump_out_valid;
        d_rdata = dump_out_data;
      end
      else if (is_cached)
      begin
        if (dir_level != '0 || cache_busy_reg)
        begin
          d_retry = 1'b1;
        end
        else if (hit)
        begin
          d_hold = 1'b1;
          d_lat_flush = is_slow;
        end
        else
        begin
          d_fetch_start = 1'b1;
          d_retry = ~retry_disable;
          d_fetch_wait = retry_disable;
          d_lat_flush = is_slow;
        end
      end
      else
      begin
        d_reg = 1'b1;
        d_hold = 1'b1;
        d_src_reg = 1'b1;
      end
    end
    // Retry and disconnect both show as stop; data only when ready
    d_stop_data = req_more & ~burst_ok;
  end

  // ----------------------------------------------------------------
  // Host response
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= hbtb_pkg::ST_IDLE;
      ack_reg <= 1'b0;
      stop_reg <= 1'b0;
      abort_reg <= 1'b0;
      rdata_reg <= '0;
      lat_src_reg <= 1'b0;
      lat_stop_reg <= 1'b0;
      lat_flush_reg <= 1'b0;
      lat_word_reg <= '0;
      lat_tag_reg <= '0;
      lat_slow_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= 1'b0;
      stop_reg <= 1'b0;
      abort_reg <= 1'b0;
      unique case (state_reg)
        hbtb_pkg::ST_IDLE:
        begin
          if (take)
          begin
            lat_src_reg <= d_src_reg;
            lat_stop_reg <= d_stop_data;
            lat_flush_reg <= d_lat_flush;
            lat_word_reg <= req_addr[3:2];
            lat_tag_reg <= req_addr[ADDR_W-1:4];
            lat_slow_reg <= is_slow;
            if (d_hold)
            begin
              state_reg <= hbtb_pkg::ST_HOLD;
            end
            else if (d_fetch_wait)
            begin
              state_reg <= hbtb_pkg::ST_FETCH;
            end
            else
            begin
              // Retry leaves no queue state changed; a retried read miss still starts a cache fetch
              ack_reg <= d_ack;
              stop_reg <= d_retry | d_abort | (d_ack & d_stop_data);
              abort_reg <= d_abort;
              rdata_reg <= d_rdata;
              state_reg <= hbtb_pkg::ST_GAP;
            end
          end
        end
        hbtb_pkg::ST_HOLD:
        begin
          ack_reg <= 1'b1;
          stop_reg <= lat_stop_reg;
          rdata_reg <= lat_src_reg ? reg_rdata : cache_data[lat_word_reg];
          state_reg <= hbtb_pkg::ST_GAP;
        end
        hbtb_pkg::ST_FETCH:
        begin
          if (!cache_busy_reg)
          begin
            ack_reg <= cache_valid_reg;
            stop_reg <= ~cache_valid_reg | lat_stop_reg;
            rdata_reg <= cache_data[lat_word_reg];
            state_reg <= hbtb_pkg::ST_GAP;
          end
        end
        hbtb_pkg::ST_GAP:
        begin
          state_reg <= hbtb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      abort_flag_reg <= 1'b0;
    end
    else if (d_abort)
    begin
      abort_flag_reg <= 1'b1;
    end
    else if (abort_flag_clear)
    begin
      abort_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read cache
  // ----------------------------------------------------------------
  // A slow read is used once, then dropped
  assign flush_now = d_flush
    | (lat_flush_reg & ack_reg & (state_reg == hbtb_pkg::ST_GAP));

  always_ff @(posedge clock)
  begin
    if (cache_busy_reg && fetch_valid)
    begin
      cache_data[fill_idx_reg] <= fetch_data;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cache_valid_reg <= 1'b0;
      cache_busy_reg <= 1'b0;
      cache_stale_reg <= 1'b0;
      cache_slow_reg <= 1'b0;
      cache_tag_reg <= '0;
      fill_idx_reg <= '0;
      fetch_req_reg <= 1'b0;
      fetch_single_reg <= 1'b0;
      fetch_addr_reg <= '0;
    end
    else
    begin
      if (d_fetch_start)
      begin
        cache_valid_reg <= 1'b0;
        cache_busy_reg <= 1'b1;
        cache_stale_reg <= 1'b0;
        cache_slow_reg <= is_slow;
        cache_tag_reg <= req_addr[ADDR_W-1:4];
        fill_idx_reg <= is_slow ? req_addr[3:2] : 2'h0;
        fetch_req_reg <= 1'b1;
        fetch_single_reg <= is_slow;
        fetch_addr_reg <= is_slow ? req_addr : {req_addr[ADDR_W-1:4], 4'h0};
      end
      else
      begin
        if (cache_busy_reg && fetch_valid)
        begin
          fill_idx_reg <= fill_idx_reg + 2'h1;
          if (fetch_last)
          begin
            cache_busy_reg <= 1'b0;
            fetch_req_reg <= 1'b0;
            cache_valid_reg <= ~cache_stale_reg & ~flush_now;
          end
        end
        if (flush_now)
        begin
          cache_valid_reg <= 1'b0;
          cache_stale_reg <= cache_busy_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Unbuffered register port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reg_strobe_reg <= 1'b0;
      reg_write_reg <= 1'b0;
      reg_class_reg <= hbtb_pkg::CLS_CONFIG;
      reg_addr_reg <= '0;
      reg_be_n_reg <= 4'hf;
      reg_wdata_reg <= '0;
    end
    else
    begin
      reg_strobe_reg <= d_reg;
      if (d_reg)
      begin
        reg_write_reg <= req_write;
        reg_class_reg <= req_class;
        reg_addr_reg <= req_addr;
        reg_be_n_reg <= byte_enable_pins_n;
        reg_wdata_reg <= req_wdata;
      end
    end
  end

  assign resp_ack = ack_reg;
  assign resp_stop = stop_reg;
  assign resp_abort = abort_reg;
  assign resp_rdata = rdata_reg;
  assign abort_flag = abort_flag_reg;
  assign fetch_req = fetch_req_reg;
  assign fetch_addr = fetch_addr_reg;
  assign fetch_single = fetch_single_reg;
  assign reg_strobe = reg_strobe_reg;
  assign reg_write = reg_write_reg;
  assign reg_class = reg_class_reg;
  assign reg_addr = reg_addr_reg;
  assign reg_be_n = reg_be_n_reg;
  assign reg_wdata = reg_wdata_reg;

endmodule : hbtb_target

`default_nettype wire

// file: verif/hbtb_target_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module hbtb_target_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire hbtb_pkg::hbtb_space_t req_space,
  input wire hbtb_pkg::hbtb_class_t req_class,
  input wire logic req_write,
  input wire logic retry_disable,
  input wire logic resp_ack,
  input wire logic resp_stop,
  input wire logic resp_abort,
  input wire logic abort_flag,
  input wire logic abort_flag_clear,
  input wire logic dir_valid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_answer;
    resp_ack || resp_stop || resp_abort;
  endsequence

  sequence s_quiet;
    !resp_ack && !resp_stop && !resp_abort;
  endsequence

  property p_abort_io;
    resp_abort |-> $past(req_space) == hbtb_pkg::SP_IO;
  endproperty
  a_abort_io: assert property (p_abort_io) else $error("abort outside io space");

  property p_abort_form;
    resp_abort |-> resp_stop && !resp_ack;
  endproperty
  a_abort_form: assert property (p_abort_form) else $error("abort without stop");

  property p_abort_sets_flag;
    resp_abort |-> ##[0:1] abort_flag;
  endproperty
  a_abort_sets_flag: assert property (p_abort_sets_flag) else $error("flag not set");

  property p_flag_cause;
    $rose(abort_flag) |-> resp_abort || $past(resp_abort);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without abort");

  property p_flag_clear;
    abort_flag_clear && !resp_abort && !$past(resp_abort) |=> !abort_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_pulse;
    s_answer |=> s_quiet;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");

  property p_first_phase;
    $rose(req_valid) && !retry_disable |-> ##[1:16] s_answer;
  endproperty
  a_first_phase: assert property (p_first_phase) else $error("no answer in 16 clocks");

  property p_vga_order;
    resp_ack && $past(req_write) && $past(req_class) == hbtb_pkg::CLS_VGAREG |-> !$past(dir_valid);
  endproperty
  a_vga_order: assert property (p_vga_order) else $error("vga write with queue busy");
endmodule : hbtb_target_monitor

bind hbtb_target hbtb_target_monitor i_hbtb_target_monitor (
  .clock(clock),
  .rst(rst),
  .req_valid(req_valid),
  .req_space(req_space),
  .req_class(req_class),
  .req_write(req_write),
  .retry_disable(retry_disable),
  .resp_ack(resp_ack),
  .resp_stop(resp_stop),
  .resp_abort(resp_abort),
  .abort_flag(abort_flag),
  .abort_flag_clear(abort_flag_clear),
  .dir_valid(dir_valid)
);

`default_nettype wire

// file: verif/hbtb_units_model.sv
`timescale 1ns/100ps
`default_nettype none

module hbtb_units_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic stall,
  input wire logic fill,
  input wire logic draw_valid,
  output logic draw_ready,
  input wire logic dir_valid,
  output logic dir_ready,
  output logic dump_valid,
  input wire logic dump_ready,
  output logic [31:0] dump_data,
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  input wire logic fetch_single,
  output logic fetch_valid,
  output logic fetch_last,
  output logic [31:0] fetch_data,
  input wire logic reg_strobe,
  input wire logic [23:0] reg_addr,
  output logic [31:0] reg_rdata
);
  logic [31:0] dcnt_reg;
  logic [3:0] beat_reg;
  logic [1:0] slot;
  logic [3:0] last_beat;

  assign draw_ready = !stall;
  assign dir_ready = !stall;
  assign dump_valid = fill;
  assign dump_data = fill ? dcnt_reg : ~dcnt_reg;

  always_ff @(posedge clock or posedge rst)
    if (rst)
      dcnt_reg <= 32'h0;
    else if (fill && dump_ready)
      dcnt_reg <= dcnt_reg + 32'h1;

  // ----
  // Memory fetch: beats start two cycles after the request
  // ----
  assign last_beat = fetch_single ? 4'h2 : 4'h5;
  assign slot = fetch_single ? fetch_addr[3:2] : beat_reg[1:0] - 2'h2;
  assign fetch_valid = fetch_req && beat_reg >= 4'h2 && beat_reg <= last_beat;
  assign fetch_last = fetch_valid && beat_reg == last_beat;
  assign fetch_data = fetch_valid ? {8'hd0, fetch_addr[23:4], slot, 2'h0} : {28'h0, beat_reg};

  always_ff @(posedge clock or posedge rst)
    if (rst)
      beat_reg <= 4'h0;
    else
      beat_reg <= fetch_req ? beat_reg + 4'h1 : 4'h0;

  // Read data stands while the strobe is high, junk otherwise
  assign reg_rdata = reg_strobe ? {8'hc0, reg_addr} : ~{8'hc0, reg_addr};
endmodule : hbtb_units_model

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam logic [2:0] ACK = 3'h1;
  localparam logic [2:0] RTY = 3'h2;
  localparam logic [2:0] DIS = 3'h3;
  localparam logic [2:0] ABT = 3'h6;
  logic clock, rst, req_valid, req_write, req_more, retry_disable, abort_flag_clear, stall, fill;
  hbtb_pkg::hbtb_space_t req_space;
  hbtb_pkg::hbtb_class_t req_class;
  logic [23:0] req_addr, fetch_addr, reg_addr;
  logic [3:0] be_n;
  logic [31:0] resp_rdata, dump_data, fetch_data, reg_rdata, rd;
  logic resp_ack, resp_stop, resp_abort, abort_flag, draw_valid, draw_ready, dir_valid, dir_ready;
  logic dump_valid, dump_ready, fetch_req, fetch_single, fetch_valid, fetch_last, reg_strobe;
  int lat;
  int cyc;
  int error_cnt = 0;
  int samples_checked = 0;

  hbtb_target i_hbtb_target (
    .clock, .rst, .req_valid, .req_space, .req_class, .req_write, .req_first(1'b1), .req_more,
    .req_addr, .byte_enable_pins_n(be_n), .io_lane_unit(8'he4), .req_wdata({8'h5a, req_addr}),
    .native_mode(1'b1), .retry_disable, .resp_ack, .resp_stop, .resp_abort, .resp_rdata,
    .abort_flag, .abort_flag_clear, .draw_valid, .draw_ready, .draw_data(), .dir_valid,
    .dir_ready, .dir_data(), .dump_valid, .dump_ready, .dump_data, .fetch_req, .fetch_addr,
    .fetch_single, .fetch_valid, .fetch_last, .fetch_data, .reg_strobe, .reg_write(),
    .reg_class(), .reg_addr, .reg_be_n(), .reg_wdata(), .reg_rdata
  );

  hbtb_units_model i_hbtb_units_model (
    .clock, .rst, .stall, .fill, .draw_valid, .draw_ready, .dir_valid, .dir_ready, .dump_valid,
    .dump_ready, .dump_data, .fetch_req, .fetch_addr, .fetch_single, .fetch_valid, .fetch_last,
    .fetch_data, .reg_strobe, .reg_addr, .reg_rdata
  );

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One data phase: hold the request until an answer, then one gap cycle
  task automatic xfer(input hbtb_pkg::hbtb_class_t c, input logic w, input logic m,
    input logic [23:0] a, input logic [2:0] e);
    logic [2:0] ans;
    lat = 0;
    ans = 3'h0;
    req_class = c;
    req_write = w;
    req_more = m;
    req_addr = a;
    req_valid = 1'b1;
    while (ans === 3'h0 && lat < 80)
    begin
      @(negedge clock);
      lat++;
      ans = {resp_abort, resp_stop, resp_ack};
    end
    rd = resp_rdata;
    req_valid = 1'b0;
    @(negedge clock);
    chk({29'h0, ans}, {29'h0, e});
  endtask : xfer

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // ----
  // Scenarios
  // ----
  task automatic t_dump;
    xfer(hbtb_pkg::CLS_PSEUDO_DMA_WINDOW, 1'b0, 1'b1, 24'h000000, RTY);
    fill = 1'b1;
    repeat (8) @(negedge clock);
    chk({31'h0, dump_ready}, 32'h0);
    fill = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      xfer(hbtb_pkg::CLS_PSEUDO_DMA_WINDOW, 1'b0, i < 3, 24'h000000, ACK);
      chk(rd, i);
    end
    xfer(hbtb_pkg::CLS_PSEUDO_DMA_WINDOW, 1'b0, 1'b1, 24'h000000, RTY);
    $display("dump test done");
  endtask : t_dump

  task automatic t_abort;
    logic [7:0] t [6] = '{8'h0e, 8'h9e, 8'ha7, 8'h37, 8'h8c, 8'h0f};
    req_space = hbtb_pkg::SP_IO;
    foreach (t[i])
    begin
      be_n = t[i][3:0];
      xfer(hbtb_pkg::CLS_VGAREG, 1'b0, 1'b0, {22'h0, t[i][5:4]}, t[i][7] ? ABT : ACK);
    end
    chk({31'h0, abort_flag}, 32'h1);
    req_space = hbtb_pkg::SP_MEM;
    be_n = 4'he;
    xfer(hbtb_pkg::CLS_VGAREG, 1'b0, 1'b0, 24'h000001, ACK);
    be_n = 4'h0;
    abort_flag_clear = 1'b1;
    @(negedge clock);
    abort_flag_clear = 1'b0;
    @(negedge clock);
    chk({31'h0, abort_flag}, 32'h0);
    $display("abort test done");
  endtask : t_abort

  task automatic t_draw;
    stall = 1'b1;
    for (int i = 0; i < 64; i++)
      xfer(hbtb_pkg::CLS_DRAWREG, 1'b1, 1'b1, 24'h000100, ACK);
    xfer(hbtb_pkg::CLS_DRAWREG, 1'b1, 1'b0, 24'h000100, RTY);
    xfer(hbtb_pkg::CLS_PSEUDO_DMA_WINDOW, 1'b1, 1'b0, 24'h000000, RTY);
    stall = 1'b0;
    repeat (4) @(negedge clock);
    xfer(hbtb_pkg::CLS_INDIRECT, 1'b1, 1'b0, 24'h000100, ACK);
    repeat (80) @(negedge clock);
    $display("drawing queue test done");
  endtask : t_draw

  task automatic t_dir;
    stall = 1'b1;
    for (int i = 0; i < 8; i++)
      xfer(hbtb_pkg::CLS_FRAME, 1'b1, 1'b1, 24'h000200, ACK);
    xfer(hbtb_pkg::CLS_DAC, 1'b1, 1'b0, 24'h000300, RTY);
    xfer(hbtb_pkg::CLS_VGAREG, 1'b1, 1'b0, 24'h000300, RTY);
    xfer(hbtb_pkg::CLS_FRAME, 1'b0, 1'b0, 24'h000200, RTY);
    stall = 1'b0;
    repeat (20) @(negedge clock);
    $display("direct queue test done");
  endtask : t_dir

  task automatic t_cache;
    xfer(hbtb_pkg::CLS_FRAME, 1'b0, 1'b0, 24'h000104, RTY);
    repeat (20) @(negedge clock);
    xfer(hbtb_pkg::CLS_FRAME, 1'b0, 1'b1, 24'h000108, ACK);
    chk(lat, 2);
    chk(rd, 32'hd0000108);
    xfer(hbtb_pkg::CLS_DRAWREG, 1'b1, 1'b0, 24'h000010, ACK);
    xfer(hbtb_pkg::CLS_FRAME, 1'b0, 1'b0, 24'h00010c, ACK);
    chk(rd, 32'hd000010c);
    xfer(hbtb_pkg::CLS_VGAREG, 1'b1, 1'b0, 24'h001fff, ACK);
    xfer(hbtb_pkg::CLS_FRAME, 1'b0, 1'b0, 24'h00010c, RTY);
    retry_disable = 1'b1;
    repeat (20) @(negedge clock);
    xfer(hbtb_pkg::CLS_DAC, 1'b0, 1'b0, 24'h000204, ACK);
    chk(rd, 32'hd0000204);
    retry_disable = 1'b0;
    xfer(hbtb_pkg::CLS_HOSTREG, 1'b0, 1'b0, 24'h000010, ACK);
    chk(rd, 32'hc0000010);
    xfer(hbtb_pkg::CLS_HOSTREG, 1'b1, 1'b1, 24'h000010, DIS);
    $display("cache test done");
  endtask : t_cache

  // ----
  // Main sequence and hang guard
  // ----
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_more = 1'b0;
    req_space = hbtb_pkg::SP_MEM;
    req_class = hbtb_pkg::CLS_CONFIG;
    req_addr = 24'h0;
    be_n = 4'h0;
    retry_disable = 1'b0;
    abort_flag_clear = 1'b0;
    stall = 1'b0;
    fill = 1'b0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    t_dump;
    t_abort;
    t_draw;
    t_dir;
    t_cache;
    test_done;
  end

  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge clock);
      cyc++;
      if (cyc == 20000)
      begin
        error_cnt++;
        test_done;
      end
    end
  end
endmodule : tb_top

`default_nettype wire
